// >>> rsr_regs.sv
// buck-boost setpoint and core slew control register bank with ramp engine
`timescale 1ns/10ps
module rsr_regs #(
    parameter int         BLANK_CYCLES = rsr_pkg::BLANK_CYCLES_DEF,
    parameter int         STEP_UNIT    = rsr_pkg::STEP_UNIT_DEF,
    parameter logic [6:0] DEV_ADDR     = rsr_pkg::DEV_ADDR_DEF
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        PASSWORD_OK,
    input  wire logic [5:0]  CORE1_TARGET,
    input  wire logic [5:0]  CORE2_TARGET,
    input  wire logic        CORE_SETPT_WR,
    output logic             PULSE_SKIP_EN,
    output logic [5:0]       BB_VOLT_CODE,
    output logic [11:0]      BB_MILLIVOLT,
    output logic             SUPV_BLANK,
    output logic [5:0]       CORE1_LEVEL,
    output logic [5:0]       CORE2_LEVEL,
    output logic             RAMP_BUSY
);
    import rsr_pkg::*;

    rsr_wr_t     wr;
    logic [7:0]  rd_addr, rd_data, sp_view_c, slew_view_c;
    logic        trig_r, byp_r;
    logic [2:0]  rate_r, rate_nxt;
    logic [23:0] blank_cnt_r, step_cnt_r;
    logic        sp_wr_c, slew_wr_c, go_c, done_c;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // code to output millivolts
    function automatic logic [11:0] bb_code_to_mv(input logic [5:0] code);
        if (code <= BB_KNEE_CODE) return BB_BASE_MV + 12'(code) * BB_FINE_MV;
        else return BB_KNEE_MV + 12'(code - BB_KNEE_CODE) * BB_COARSE_MV;
    endfunction

    // cycles per ramp step for a rate code
    function automatic logic [23:0] step_cycles(input logic [2:0] rate);
        return 24'(STEP_UNIT) << (RATE_FASTEST - rate);
    endfunction

    // one code toward the target
    function automatic logic [5:0] step_toward(input logic [5:0] lvl, input logic [5:0] tgt);
        if (lvl < tgt) return lvl + 6'h01;
        else if (lvl > tgt) return lvl - 6'h01;
        else return lvl;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // serial front end

    rsr_i2c_target #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .clk     (CLK_SYS),
        .rst_n   (RSTN),
        .scl     (SCL),
        .sda_in  (SDA_IN),
        .rd_data (rd_data),
        .wr      (wr),
        .rd_addr (rd_addr),
        .sda_oe  (SDA_OE)
    );

    // open-drain line only ever pulled low
    always_ff @(posedge CLK_SYS) begin
        SDA_OUT <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decode and read back

    assign sp_wr_c   = wr.stb && wr.addr == SP_ADDR && PASSWORD_OK;
    assign slew_wr_c = wr.stb && wr.addr == SLEW_ADDR;
    assign rate_nxt  = slew_wr_c ? wr.data[SLEW_RATE_MSB:0] : rate_r;
    assign go_c      = (slew_wr_c && wr.data[SLEW_TRIG_BIT])
                    || (byp_r && CORE_SETPT_WR);
    assign done_c    = RAMP_BUSY && CORE1_LEVEL == CORE1_TARGET && CORE2_LEVEL == CORE2_TARGET;

    // register views with reserved bits at zero
    assign sp_view_c   = {PULSE_SKIP_EN, 1'b0, BB_VOLT_CODE};
    assign slew_view_c = {trig_r, byp_r, 3'b000, rate_r};

    // read mux, unmapped subaddresses read zero
    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == SP_ADDR) rd_data = sp_view_c;
        else if (rd_addr == SLEW_ADDR) rd_data = slew_view_c;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buck-boost setpoint

    // setpoint storage, locked unless unlocked
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            PULSE_SKIP_EN <= SP_RESET[SP_PSK_BIT];
            BB_VOLT_CODE  <= SP_RESET[SP_CODE_MSB:0];
        end else if (sp_wr_c) begin
            PULSE_SKIP_EN <= wr.data[SP_PSK_BIT];
            BB_VOLT_CODE  <= wr.data[SP_CODE_MSB:0];
        end
    end

    // output level in millivolts for the analog side
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) BB_MILLIVOLT <= bb_code_to_mv(SP_RESET[SP_CODE_MSB:0]);
        else BB_MILLIVOLT <= bb_code_to_mv(BB_VOLT_CODE);
    end

    // supervision blanking after each setpoint write
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            blank_cnt_r <= 24'h000000;
            SUPV_BLANK  <= 1'b0;
        end else begin
            SUPV_BLANK <= sp_wr_c || blank_cnt_r > 24'h000001;
            if (sp_wr_c) blank_cnt_r <= 24'(BLANK_CYCLES);
            else if (blank_cnt_r != 24'h000000) blank_cnt_r <= blank_cnt_r - 24'h000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // slew control

    // bypass and rate fields
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            byp_r  <= SLEW_RESET[SLEW_BYP_BIT];
            rate_r <= SLEW_RESET[SLEW_RATE_MSB:0];
        end else if (slew_wr_c) begin
            byp_r  <= wr.data[SLEW_BYP_BIT];
            rate_r <= rate_nxt;
        end
    end

    // trigger: set by a write of one, cleared at ramp end, set wins
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) trig_r <= SLEW_RESET[SLEW_TRIG_BIT];
        else if (slew_wr_c && wr.data[SLEW_TRIG_BIT]) trig_r <= 1'b1;
        else if (done_c) trig_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core ramp engine, buck-boost never passes through here

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            RAMP_BUSY   <= 1'b0;
            step_cnt_r  <= 24'h000000;
            CORE1_LEVEL <= 6'h00;
            CORE2_LEVEL <= 6'h00;
        end else if (go_c) begin
            RAMP_BUSY  <= 1'b1;
            step_cnt_r <= step_cycles(rate_nxt) - 24'h000001;
        end else if (done_c) begin
            RAMP_BUSY <= 1'b0;
        end else if (RAMP_BUSY) begin
            if (rate_r == RATE_IMMEDIATE) begin
                CORE1_LEVEL <= CORE1_TARGET;
                CORE2_LEVEL <= CORE2_TARGET;
            end else if (step_cnt_r == 24'h000000) begin
                step_cnt_r  <= step_cycles(rate_r) - 24'h000001;
                CORE1_LEVEL <= step_toward(CORE1_LEVEL, CORE1_TARGET);
                CORE2_LEVEL <= step_toward(CORE2_LEVEL, CORE2_TARGET);
            end else begin
                step_cnt_r <= step_cnt_r - 24'h000001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    sequence s_sp_write;
        sp_wr_c;
    endsequence

    sequence s_blank_run;
        SUPV_BLANK [*8];
    endsequence

    property p_sp_store;
        s_sp_write |=> sp_view_c == ($past(wr.data) & 8'hBF);
    endproperty
    a_sp_store: assert property (p_sp_store) else $error("setpoint write not stored");

    property p_sp_locked;
        wr.stb && wr.addr == SP_ADDR && !PASSWORD_OK |=> $stable(sp_view_c);
    endproperty
    a_sp_locked: assert property (p_sp_locked) else $error("locked setpoint changed");

    property p_blank;
        s_sp_write |=> s_blank_run;
    endproperty
    a_blank: assert property (p_blank) else $error("blanking not held after write");

    property p_mv_top;
        BB_VOLT_CODE == 6'h34 && $stable(BB_VOLT_CODE) |-> BB_MILLIVOLT == 12'hD48;
    endproperty
    a_mv_top: assert property (p_mv_top) else $error("top code not 3400 mV");

    property p_slew_store;
        slew_wr_c |=> (slew_view_c & 8'h7F) == ($past(wr.data) & 8'h47);
    endproperty
    a_slew_store: assert property (p_slew_store) else $error("slew write not stored");

    property p_bb_unslewed;
        RAMP_BUSY && !sp_wr_c |=> $stable(BB_VOLT_CODE);
    endproperty
    a_bb_unslewed: assert property (p_bb_unslewed) else $error("ramp moved buck-boost");

    property p_trig_clear;
        done_c && !go_c |=> !trig_r && !RAMP_BUSY;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared at end");

    property p_bypass;
        byp_r && CORE_SETPT_WR |=> RAMP_BUSY;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass write did not ramp");

    property p_immediate;
        RAMP_BUSY && rate_r == RATE_IMMEDIATE && !go_c && !done_c
            |=> CORE1_LEVEL == $past(CORE1_TARGET) && CORE2_LEVEL == $past(CORE2_TARGET);
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate rate not at once");

    property p_step_gap;
        STEP_UNIT > 9 && $changed(CORE1_LEVEL) && !go_c |=> $stable(CORE1_LEVEL) [*8];
    endproperty
    a_step_gap: assert property (p_step_gap) else $error("core steps too close");
endmodule

// >>> rsr_pkg.sv
// shared constants and carrier types for the setpoint and slew register bank
package rsr_pkg;
    // register subaddresses and reset values
    localparam logic [7:0]  SP_ADDR          = 8'h19;
    localparam logic [7:0]  SLEW_ADDR        = 8'h1A;
    localparam logic [7:0]  SP_RESET         = 8'hB2;
    localparam logic [7:0]  SLEW_RESET       = 8'h06;
    // field positions
    localparam int          SP_PSK_BIT       = 7;
    localparam int          SP_CODE_MSB      = 5;
    localparam int          SLEW_TRIG_BIT    = 7;
    localparam int          SLEW_BYP_BIT     = 6;
    localparam int          SLEW_RATE_MSB    = 2;
    // rate codes
    localparam logic [2:0]  RATE_FASTEST     = 3'h6;
    localparam logic [2:0]  RATE_IMMEDIATE   = 3'h7;
    // buck-boost code to millivolt mapping
    localparam logic [5:0]  BB_KNEE_CODE     = 6'h0F;
    localparam logic [11:0] BB_BASE_MV       = 12'h497;
    localparam logic [11:0] BB_FINE_MV       = 12'h019;
    localparam logic [11:0] BB_KNEE_MV       = 12'h60E;
    localparam logic [11:0] BB_COARSE_MV     = 12'h032;
    // timing
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          BLANK_TIME_MS    = 5;
    localparam int          BLANK_CYCLES_DEF = BLANK_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int          STEP_UNIT_NS     = 2500;
    localparam int          STEP_UNIT_DEF    = STEP_UNIT_NS / CLK_PERIOD_NS;
    // target address on the serial bus, value arbitrary
    localparam logic [6:0]  DEV_ADDR_DEF     = 7'h2A;

    // one register write from the serial front end
    typedef struct packed {
        logic       stb;
        logic [7:0] addr;
        logic [7:0] data;
    } rsr_wr_t;
endpackage

// >>> rsr_i2c_target.sv
// serial two-wire target that turns bus transfers into register accesses
`timescale 1ns/10ps
module rsr_i2c_target #(
    parameter logic [6:0] DEV_ADDR = rsr_pkg::DEV_ADDR_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl,
    input  wire logic        sda_in,
    input  wire logic [7:0]  rd_data,
    output rsr_pkg::rsr_wr_t wr,
    output logic [7:0]       rd_addr,
    output logic             sda_oe
);
    import rsr_pkg::*;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001, S_ADDR = 9'h002, S_AACK = 9'h004, S_SUB  = 9'h008,
        S_SACK = 9'h010, S_WDAT = 9'h020, S_WACK = 9'h040, S_RDAT = 9'h080,
        S_RACK = 9'h100
    } rsr_i2c_st_t;

    rsr_i2c_st_t st_r;
    logic        scl_q, sda_q, rw_r, nack_r;
    logic [7:0]  sh_r;
    logic [3:0]  cnt_r;
    logic        start_c, stop_c, rise_c, fall_c;

    // bus condition detection
    assign start_c = scl && scl_q && sda_q && !sda_in;
    assign stop_c  = scl && scl_q && !sda_q && sda_in;
    assign rise_c  = scl && !scl_q;
    assign fall_c  = !scl && scl_q;

    // previous line levels
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // write strobe, one cycle per received data byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr <= '0;
        end else begin
            wr.stb  <= fall_c && st_r == S_WDAT && cnt_r == 4'h8;
            wr.addr <= rd_addr;
            wr.data <= sh_r;
        end
    end

    // transfer sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r    <= S_IDLE;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
            rw_r    <= 1'b0;
            nack_r  <= 1'b0;
            sda_oe  <= 1'b0;
            rd_addr <= 8'h00;
        end else if (start_c) begin
            st_r   <= S_ADDR;
            cnt_r  <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop_c) begin
            st_r   <= S_IDLE;
            sda_oe <= 1'b0;
        end else if (rise_c) begin
            if (st_r == S_ADDR || st_r == S_SUB || st_r == S_WDAT) begin
                sh_r  <= {sh_r[6:0], sda_in};
                cnt_r <= cnt_r + 4'h1;
            end
            if (st_r == S_RACK) nack_r <= sda_in;
        end else if (fall_c) begin
            unique case (st_r)
                S_IDLE: ;
                S_ADDR: if (cnt_r == 4'h8) begin
                    if (sh_r[7:1] == DEV_ADDR) begin
                        st_r   <= S_AACK;
                        rw_r   <= sh_r[0];
                        sda_oe <= 1'b1;
                    end else begin
                        st_r <= S_IDLE;
                    end
                end
                S_SUB: if (cnt_r == 4'h8) begin
                    rd_addr <= sh_r;
                    st_r    <= S_SACK;
                    sda_oe  <= 1'b1;
                end
                S_WDAT: if (cnt_r == 4'h8) begin
                    st_r   <= S_WACK;
                    sda_oe <= 1'b1;
                end
                S_AACK: begin
                    cnt_r <= 4'h0;
                    if (rw_r) begin
                        st_r   <= S_RDAT;
                        sh_r   <= rd_data;
                        sda_oe <= !rd_data[7];
                    end else begin
                        st_r   <= S_SUB;
                        sda_oe <= 1'b0;
                    end
                end
                S_SACK, S_WACK: begin
                    cnt_r  <= 4'h0;
                    sda_oe <= 1'b0;
                    st_r   <= S_WDAT;
                    if (st_r == S_WACK) rd_addr <= rd_addr + 8'h01;
                end
                S_RDAT: begin
                    cnt_r  <= cnt_r + 4'h1;
                    sh_r   <= {sh_r[6:0], 1'b0};
                    sda_oe <= (cnt_r == 4'h7) ? 1'b0 : !sh_r[6];
                    if (cnt_r == 4'h7) st_r <= S_RACK;
                end
                S_RACK: begin
                    if (nack_r) begin
                        st_r <= S_IDLE;
                    end else begin
                        st_r   <= S_RDAT;
                        cnt_r  <= 4'h0;
                        sh_r   <= rd_data;
                        sda_oe <= !rd_data[7];
                    end
                end
            endcase
        end
    end
endmodule

// >>> rsr_host.sv
// two-wire bus controller model standing in for the host processor
`timescale 1ns/10ps
module rsr_host (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    import rsr_pkg::*;
    // bus idle: clock high, data released to the pull-up
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // every bus level held five clocks, changes only at falling edges
    task automatic half();
        repeat (5) @(negedge clk);
    endtask
    // start, also used as repeated start with the clock low
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
        @(negedge clk);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // one bit out and in; data only moves while the clock is low
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        half();
        scl = 1'b1;
        half();
        s   = sda;
        scl = 1'b0;
        @(negedge clk);
    endtask
    // one byte msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // register write; reserved buck-boost codes are never sent
    task automatic reg_write(input logic [6:0] dev, input logic [7:0] sub,
                             input logic [7:0] data, output logic ok);
        logic [7:0] rx;
        logic       a0, a1, a2;
        if (sub == SP_ADDR && data[5:0] > 6'h34) data[5:0] = 6'h34;
        start();
        xfer({dev, 1'b0}, rx, a0);
        xfer(sub, rx, a1);
        xfer(data, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    // register read: set pointer, repeated start, one byte, no acknowledge
    task automatic reg_read(input logic [7:0] sub, output logic [7:0] data);
        logic [7:0] rx;
        logic       a;
        start();
        xfer({DEV_ADDR_DEF, 1'b0}, rx, a);
        xfer(sub, rx, a);
        start();
        xfer({DEV_ADDR_DEF, 1'b1}, rx, a);
        xfer(8'hFF, data, a);
        stop();
    endtask
endmodule

// >>> testbench.sv
// self-checking bench for the setpoint and slew register bank
`timescale 1ns/10ps
module testbench;
    import rsr_pkg::*;
    localparam int BLK  = 20;
    localparam int UNIT = 12;
    logic             clk_sys = 1'b0;
    logic             rstn    = 1'b0;
    logic             pw_ok   = 1'b1;
    logic             core_wr = 1'b0;
    logic [5:0]       t1      = 6'h00;
    logic [5:0]       t2      = 6'h00;
    logic             ok_r;
    wire logic        scl, sda_low, sda_oe, sda_out, psk, blank, busy;
    wire logic [5:0]  code, lvl1, lvl2;
    wire logic [11:0] mv;
    wire logic        sda = !(sda_low || sda_oe);
    integer           seed = 43085;
    int               failures = 0;
    int               compares = 0;
    int               blank_n = 0;
    int               busy_n = 0;
    logic [15:0]      exp_q [$];
    logic [15:0]      act_q [$];
    logic [5:0]       tbl [4] = '{6'h00, 6'h0F, 6'h10, 6'h34};

    always #5 clk_sys = ~clk_sys;

    rsr_regs #(.BLANK_CYCLES(BLK), .STEP_UNIT(UNIT)) rsr_regs_i (
        .CLK_SYS(clk_sys), .RSTN(rstn), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .PASSWORD_OK(pw_ok), .CORE1_TARGET(t1), .CORE2_TARGET(t2),
        .CORE_SETPT_WR(core_wr), .PULSE_SKIP_EN(psk), .BB_VOLT_CODE(code),
        .BB_MILLIVOLT(mv), .SUPV_BLANK(blank), .CORE1_LEVEL(lvl1), .CORE2_LEVEL(lvl2),
        .RAMP_BUSY(busy));
    rsr_host rsr_host_i (.clk(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
    ////////////////////////////////////////////////////////////////////////
    // pulse lengths of blanking and ramp become results on falling edges
    always @(negedge clk_sys) begin
        if (blank === 1'b1) blank_n++;
        else if (blank_n != 0) begin
            act_q.push_back(16'(blank_n));
            blank_n = 0;
        end
        if (busy === 1'b1) busy_n++;
        else if (busy_n != 0) begin
            act_q.push_back(16'(busy_n));
            busy_n = 0;
        end
    end
    // each result against the oldest expectation
    initial begin
        logic [15:0] e;
        forever begin
            @(negedge clk_sys);
            while (act_q.size() > 0) begin
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
                compares++;
                if (e !== act_q[0]) begin
                    failures++;
                    $display("CHECK FAILED at %0t: expected %h got %h", $time, e, act_q[0]);
                end
                void'(act_q.pop_front());
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic note(input logic [15:0] e, input logic [15:0] a);
        exp_q.push_back(e);
        act_q.push_back(a);
    endtask
    task automatic wr(input logic [7:0] s, input logic [7:0] d);
        rsr_host_i.reg_write(DEV_ADDR_DEF, s, d, ok_r);
    endtask
    task automatic chk_rd(input logic [7:0] s, input logic [7:0] e);
        logic [7:0] d;
        rsr_host_i.reg_read(s, d);
        note({8'h00, e}, {8'h00, d});
    endtask
    task automatic wait_busy();
        int n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 20000) begin
            failures++;
            final_report();
        end
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic test_done(input string s);
        $display("test %s done", s);
    endtask
    task automatic final_report();
        repeat (3) @(negedge clk_sys);
        failures += exp_q.size();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [5:0] c;
        logic       p;
        int         a, b, l1, l2;
        l1 = 0;
        l2 = 0;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        note(16'h1, {15'h0, psk});
        note(16'h32, {10'h0, code});
        note(16'hCE4, {4'h0, mv});
        note(16'h0, {14'h0, blank, busy});
        note(16'h0, {14'h0, sda_oe, sda_out});
        chk_rd(SP_ADDR, 8'hB2);
        chk_rd(SLEW_ADDR, 8'h06);
        test_done("reset");
        // locked setpoint: acknowledged, not stored, no blanking
        pw_ok = 1'b0;
        wr(SP_ADDR, 8'h05);
        pw_ok = 1'b1;
        chk_rd(SP_ADDR, 8'hB2);
        test_done("locked");
        // boundary and random codes, reserved bit 6 always offered
        // buck-boost counts as disabled here, so its code may be rewritten
        for (int k = 0; k < 6; k++) begin
            c = (k < 4) ? tbl[k] : 6'($unsigned($random(seed)) % 53);
            p = k[0];
            exp_q.push_back(16'(BLK));
            wr(SP_ADDR, {p, 1'b1, c});
            repeat (4) @(negedge clk_sys);
            note(16'h1, {15'h0, ok_r});
            note({15'h0, p}, {15'h0, psk});
            note({10'h0, c}, {10'h0, code});
            note(16'(c <= 6'h0F ? 1175 + 25 * c : 1550 + 50 * (c - 15)), {4'h0, mv});
            chk_rd(SP_ADDR, {p, 1'b0, c});
        end
        rsr_host_i.reg_write(DEV_ADDR_DEF ^ 7'h01, SP_ADDR, 8'h00, ok_r);
        note(16'h0, {15'h0, ok_r});
        chk_rd(8'h1B, 8'h00);
        wr(SLEW_ADDR, 8'h3D);
        chk_rd(SLEW_ADDR, 8'h05);
        test_done("setpoint");
        // triggered ramps at every rate code
        // tight supervision counts as off, so lowering needs no pulse-skip clear
        for (int r = 0; r < 8; r++) begin
            t1 = 6'(r[0] ? 1 : 6 + ($random(seed) & 1));
            t2 = 6'(r[0] ? 5 : 2);
            a = (t1 > l1) ? t1 - l1 : l1 - t1;
            b = (t2 > l2) ? t2 - l2 : l2 - t2;
            a = (a > b) ? a : b;
            exp_q.push_back(16'((r == 7) ? 2 : a * (UNIT << (6 - r)) + 1));
            wr(SLEW_ADDR, {5'b10000, 3'(r)});
            wait_busy();
            note(16'h1, {15'h0, ok_r});
            note({10'h0, t1}, {10'h0, lvl1});
            note({10'h0, t2}, {10'h0, lvl2});
            chk_rd(SLEW_ADDR, {5'b00000, 3'(r)});
            l1 = t1;
            l2 = t2;
        end
        note({10'h0, c}, {10'h0, code});
        test_done("ramp");
        // bypass: a core setpoint write alone starts a ramp
        wr(SLEW_ADDR, 8'h47);
        chk_rd(SLEW_ADDR, 8'h47);
        exp_q.push_back(16'h2);
        t1 = 6'h2A;
        t2 = 6'h15;
        core_wr = 1'b1;
        @(negedge clk_sys);
        core_wr = 1'b0;
        repeat (6) @(negedge clk_sys);
        note(16'h2A, {10'h0, lvl1});
        note(16'h15, {10'h0, lvl2});
        wr(SLEW_ADDR, 8'h07);
        t1 = 6'h00;
        core_wr = 1'b1;
        @(negedge clk_sys);
        core_wr = 1'b0;
        repeat (20) @(negedge clk_sys);
        note(16'h2A, {10'h0, lvl1});
        test_done("bypass");
        // second reset in mid-run
        rstn = 1'b0;
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        note(16'h32, {10'h0, code});
        chk_rd(SLEW_ADDR, 8'h06);
        test_done("rereset");
        final_report();
    end
    // watchdog
    initial begin
        #1000000;
        failures++;
        final_report();
    end
endmodule
